// >>> pkg/rso_pkg.sv
package rso_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam logic [12:0] ROW_LEN      = 13'h10E0;
  localparam logic [3:0]  ROW_CNT      = 4'h9;
  localparam logic [12:0] SOH_COLS     = 13'h0090;
  localparam logic [3:0]  RSOH_ROWS    = 4'h3;

  // ----------------------------------------------------------------
  // Overhead byte positions (row index, column index from zero)
  // ----------------------------------------------------------------
  localparam logic [3:0]  OW_ROW       = 4'h1;
  localparam logic [12:0] OW_COL       = 13'h0030;
  localparam logic [3:0]  UC_ROW       = 4'h1;
  localparam logic [12:0] UC_COL       = 13'h0060;
  localparam logic [3:0]  DCC_ROW      = 4'h2;
  localparam logic [12:0] DCC_COL_0    = 13'h0000;
  localparam logic [12:0] DCC_COL_1    = 13'h0030;
  localparam logic [12:0] DCC_COL_2    = 13'h0060;
  localparam int          DCC_BYTES    = 3;

  // ----------------------------------------------------------------
  // Orderwire elastic store
  // ----------------------------------------------------------------
  localparam int          OW_RATE_BPS  = 64000;
  localparam int          WANDER_NS    = 18000;
  localparam int          ES_WANDER_BITS = (WANDER_NS * 64 + 999999) / 1000000;
  localparam int          ES_DEPTH     = 4;
  localparam int          ES_AW        = 2;
  localparam logic [1:0]  ES_START_GAP = 2'h2;

  // ----------------------------------------------------------------
  // Smoothing clock: exact 64 kHz from the system clock by accumulation
  // ----------------------------------------------------------------
  localparam int          CLK_HZ       = 10000000;
  localparam logic [13:0] ACC_STEP     = 14'(OW_RATE_BPS / 1000);
  localparam logic [13:0] ACC_MOD      = 14'(CLK_HZ / 1000);
  localparam int          AIS_LIMIT_US = 1000;
  localparam logic [7:0]  ALL_ONES     = 8'hFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       fs;
  } rso_byte_t;

  typedef struct packed {
    logic [12:0] col;
    logic [3:0]  row;
  } rso_pos_t;

endpackage

// >>> verilog/rso_adapt.sv
`timescale 1ns/100ps
// Operation
// - Payload sink forwards every byte outside the regenerator overhead with strobe and frame start.
// - Datacomm source places its client bytes in the three datacomm overhead bytes of every frame.
// - Datacomm sink extracts the three datacomm bytes of every frame and hands them out with a strobe.
// - Orderwire source inserts the octet structured 64 kbit/s client stream into one chosen byte.
// - Orderwire source buffers octets in an elastic store written by client timing, read by frame timing.
// - While just_pos_i is high and just_neg_i is low, every orderwire byte read skips one whole stored octet.
// - A negative justification reads the same stored octet a second time.
// - The elastic store is deep enough for at least 18 us of wander.
// - Orderwire source inserts only into the byte chosen by its select input.
// - Orderwire sink latches each received octet of the chosen byte into a holding store.
// - Orderwire sink shifts latched bits out on a nominal 64 kHz clock derived from the system clock.
// - Orderwire sink extracts only the byte chosen by its select input.
// - Orderwire sink sends all ones at 64 kbit/s while trail fail is high, switching within 1 ms.
// - User channel source places its client byte into the user channel byte once per frame, unless the orderwire is selected into that byte.
// - User channel sink extracts the user channel byte of every frame with a strobe.
// - User channel sink outputs all ones while trail fail is high, switching within 1 ms.
module rso_adapt
  import rso_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire rso_byte_t  rx_i,
  input  wire logic       rx_tsf_i,
  input  wire rso_byte_t  tx_i,
  input  wire logic       ow_sel_uc_i,
  output rso_byte_t       tx_o,
  output rso_byte_t       ms_o,
  output logic            ms_ssf_o,
  output rso_byte_t       dcc_rx_o,
  output logic            dcc_rx_ssf_o,
  output logic            dcc_tx_req_o,
  input  wire logic [7:0] dcc_tx_byte_i,
  output rso_byte_t       uc_rx_o,
  output logic            uc_rx_ssf_o,
  output logic            uc_tx_req_o,
  input  wire logic [7:0] uc_tx_byte_i,
  input  wire logic       ow_tx_bit_i,
  input  wire logic       ow_tx_stb_i,
  input  wire logic       ow_tx_oct_i,
  input  wire logic       just_pos_i,
  input  wire logic       just_neg_i,
  output logic            ow_rx_bit_o,
  output logic            ow_rx_ck_o,
  output logic            ow_rx_oct_o,
  output logic            ow_rx_ssf_o
);

  // ----------------------------------------------------------------
  // Frame position counters
  // ----------------------------------------------------------------
  rso_pos_t rx_pos;
  rso_pos_t tx_pos;
  rso_pos_t rx_cur;
  rso_pos_t tx_cur;

  assign rx_cur = rx_i.fs ? '0 : rx_pos;
  assign tx_cur = tx_i.fs ? '0 : tx_pos;

  function automatic rso_pos_t next_pos(input rso_pos_t p);
    rso_pos_t n;
    n = p;
    if (p.col == ROW_LEN - 13'h0001)
    begin
      n.col = '0;
      n.row = (p.row == ROW_CNT - 4'h1) ? 4'h0 : p.row + 4'h1;
    end
    else
    begin
      n.col = p.col + 13'h0001;
    end
    return n;
  endfunction

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rx_pos <= '0;
      tx_pos <= '0;
    end
    else
    begin
      if (rx_i.valid)
        rx_pos <= next_pos(rx_cur);
      if (tx_i.valid)
        tx_pos <= next_pos(tx_cur);
    end
  end

  // ----------------------------------------------------------------
  // Position decode
  // ----------------------------------------------------------------
  wire rx_in_rsoh = (rx_cur.row < RSOH_ROWS) && (rx_cur.col < SOH_COLS);
  wire rx_at_ow   = (rx_cur.row == OW_ROW) && (rx_cur.col == OW_COL);
  wire rx_at_uc   = (rx_cur.row == UC_ROW) && (rx_cur.col == UC_COL);
  wire rx_at_dcc  = (rx_cur.row == DCC_ROW) &&
                    ((rx_cur.col == DCC_COL_0) || (rx_cur.col == DCC_COL_1) || (rx_cur.col == DCC_COL_2));
  wire tx_at_ow   = (tx_cur.row == OW_ROW) && (tx_cur.col == OW_COL);
  wire tx_at_uc   = (tx_cur.row == UC_ROW) && (tx_cur.col == UC_COL);
  wire tx_at_dcc  = (tx_cur.row == DCC_ROW) &&
                    ((tx_cur.col == DCC_COL_0) || (tx_cur.col == DCC_COL_1) || (tx_cur.col == DCC_COL_2));
  wire rx_ow_sel  = ow_sel_uc_i ? rx_at_uc : rx_at_ow;
  wire tx_ow_sel  = ow_sel_uc_i ? tx_at_uc : tx_at_ow;
  wire rx_take    = rx_i.valid;
  wire tx_take    = tx_i.valid;

  // ----------------------------------------------------------------
  // Client byte requests on the transmit side
  // ----------------------------------------------------------------
  assign dcc_tx_req_o = tx_take && tx_at_dcc;
  assign uc_tx_req_o  = tx_take && tx_at_uc && !ow_sel_uc_i;

  // ----------------------------------------------------------------
  // Orderwire elastic store, write side
  // ----------------------------------------------------------------
  logic [7:0]       es_mem [ES_DEPTH];
  logic [7:0]       es_shift;
  logic [2:0]       es_bits;
  logic [ES_AW-1:0] es_wr;
  logic [ES_AW-1:0] es_rd;
  logic             es_started;

  wire [7:0] es_word  = {es_shift[6:0], ow_tx_bit_i};
  wire       es_write = ow_tx_stb_i && (es_bits == 3'h7);
  wire [ES_AW-1:0] es_step = just_neg_i ? '0 : (just_pos_i ? ES_AW'(2) : ES_AW'(1));
  wire       es_read  = tx_take && tx_ow_sel && es_started;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      es_shift   <= '0;
      es_bits    <= '0;
      es_wr      <= '0;
      es_started <= 1'b0;
    end
    else if (ow_tx_stb_i)
    begin
      es_shift <= es_word;
      es_bits  <= ow_tx_oct_i ? 3'h1 : es_bits + 3'h1;
      if (es_write)
      begin
        es_wr <= es_wr + ES_AW'(1);
        if (es_wr == ES_START_GAP - 2'h1)
          es_started <= 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ES_DEPTH; gi++)
    begin : g_es
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
          es_mem[gi] <= ALL_ONES;
        else if (es_write && (es_wr == ES_AW'(gi)))
          es_mem[gi] <= es_word;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Orderwire elastic store, read side
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      es_rd <= '0;
    else if (es_read)
      es_rd <= es_rd + es_step;
  end

  // ----------------------------------------------------------------
  // Transmit byte insertion
  // ----------------------------------------------------------------
  wire [7:0] ow_tx_byte = es_started ? es_mem[es_rd] : ALL_ONES;
  wire [7:0] next_tx_data = tx_ow_sel ? ow_tx_byte :
                            tx_at_uc  ? uc_tx_byte_i :
                            tx_at_dcc ? dcc_tx_byte_i :
                            tx_i.data;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      tx_o <= '0;
    else
      tx_o <= '{data: next_tx_data, valid: tx_i.valid, fs: tx_i.fs && tx_i.valid};
  end

  // ----------------------------------------------------------------
  // Receive extraction and fail propagation
  // ----------------------------------------------------------------
  wire [7:0] uc_rx_data = rx_tsf_i ? ALL_ONES : rx_i.data;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ms_o         <= '0;
      dcc_rx_o     <= '0;
      uc_rx_o      <= '0;
      ms_ssf_o     <= 1'b0;
      dcc_rx_ssf_o <= 1'b0;
      uc_rx_ssf_o  <= 1'b0;
      ow_rx_ssf_o  <= 1'b0;
    end
    else
    begin
      ms_o     <= '{data: rx_i.data, valid: rx_take && !rx_in_rsoh,
                    fs: rx_take && (rx_cur.row == RSOH_ROWS) && (rx_cur.col == 13'h0000)};
      dcc_rx_o <= '{data: rx_i.data, valid: rx_take && rx_at_dcc,
                    fs: rx_take && rx_at_dcc && (rx_cur.col == DCC_COL_0)};
      uc_rx_o  <= '{data: uc_rx_data, valid: rx_take && rx_at_uc, fs: rx_take && rx_at_uc};
      ms_ssf_o     <= rx_tsf_i;
      dcc_rx_ssf_o <= rx_tsf_i;
      uc_rx_ssf_o  <= rx_tsf_i;
      ow_rx_ssf_o  <= rx_tsf_i;
    end
  end

  // ----------------------------------------------------------------
  // Orderwire sink: latch and smoothing
  // ----------------------------------------------------------------
  logic [7:0]  ow_hold;
  logic        ow_hold_full;
  logic [7:0]  ow_out_shift;
  logic [2:0]  ow_out_cnt;
  logic [13:0] ow_acc;

  wire [13:0] ow_acc_sum  = ow_acc + ACC_STEP;
  wire        ow_tick     = ow_acc_sum >= ACC_MOD;
  wire        ow_latch    = rx_take && rx_ow_sel;
  wire        ow_oct_end  = ow_tick && (ow_out_cnt == 3'h7);
  wire        ow_reload   = ow_oct_end && ow_hold_full;
  wire [7:0]  ow_next_oct = ow_hold_full ? ow_hold : ALL_ONES;
  wire [7:0]  ow_src      = ow_oct_end ? ow_next_oct : ow_out_shift;
  wire        next_ow_bit = ow_src[7] | rx_tsf_i;
  wire [13:0] next_ow_acc = ow_tick ? ow_acc_sum - ACC_MOD : ow_acc_sum;
  wire [7:0]  next_ow_shift = {ow_src[6:0], 1'b1};

  // ----------------------------------------------------------------
  // Smoothing clock
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ow_acc     <= '0;
      ow_rx_ck_o <= 1'b0;
    end
    else
    begin
      ow_acc     <= next_ow_acc;
      ow_rx_ck_o <= ow_tick;
    end
  end

  // ----------------------------------------------------------------
  // Holding store
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ow_hold      <= ALL_ONES;
      ow_hold_full <= 1'b0;
    end
    else if (ow_latch)
    begin
      ow_hold      <= rx_i.data;
      ow_hold_full <= 1'b1;
    end
    else if (ow_reload)
    begin
      ow_hold_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ow_out_shift <= ALL_ONES;
      ow_out_cnt   <= 3'h7;
      ow_rx_bit_o  <= 1'b1;
      ow_rx_oct_o  <= 1'b0;
    end
    else
    begin
      ow_rx_oct_o <= ow_oct_end;
      if (ow_tick)
      begin
        ow_out_cnt   <= ow_out_cnt + 3'h1;
        ow_rx_bit_o  <= next_ow_bit;
        ow_out_shift <= next_ow_shift;
      end
    end
  end

endmodule // rso_adapt

// >>> bench/rso_adapt_asserts.sv
`timescale 1ns/100ps
module rso_adapt_asserts
  import rso_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       rx_tsf_i,
  input wire logic       ow_sel_uc_i,
  input wire logic [7:0] dcc_tx_byte_i,
  input wire logic [7:0] uc_tx_byte_i,
  input wire rso_byte_t  tx_o,
  input wire rso_byte_t  uc_rx_o,
  input wire logic       ms_ssf_o,
  input wire logic       dcc_rx_ssf_o,
  input wire logic       uc_rx_ssf_o,
  input wire logic       ow_rx_ssf_o,
  input wire logic       dcc_tx_req_o,
  input wire logic       uc_tx_req_o,
  input wire logic       ow_rx_bit_o,
  input wire logic       ow_rx_ck_o,
  input wire logic       ow_rx_oct_o
);
  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] gap;
  logic       seen;
  // ----------------------------------------------------------------
  // Smoothing clock gap counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    gap  <= (rst_i || ow_rx_ck_o) ? 9'h000 : gap + 9'h001;
    seen <= !rst_i && (seen || ow_rx_ck_o);
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MS_SSF: assert property (1'b1 |=> ms_ssf_o == $past(rx_tsf_i)) else $error("payload fail lag");
  AST_DCC_SSF: assert property ($rose(rx_tsf_i) |=> $rose(dcc_rx_ssf_o)) else $error("datacomm fail");
  AST_UC_SSF: assert property ($fell(rx_tsf_i) |=> !uc_rx_ssf_o) else $error("user fail clear");
  AST_OW_SSF: assert property (rx_tsf_i [*2] |-> ow_rx_ssf_o) else $error("orderwire fail");
  AST_UC_AIS: assert property (uc_rx_o.valid && uc_rx_ssf_o |-> uc_rx_o.data == 8'hFF) else $error("user ones");
  AST_UC_MUTE: assert property (ow_sel_uc_i |-> !uc_tx_req_o) else $error("user source not muted");
  AST_UC_INS: assert property (uc_tx_req_o |=> tx_o.valid && tx_o.data == $past(uc_tx_byte_i))
    else $error("user byte insert");
  AST_DCC_INS: assert property (dcc_tx_req_o |=> tx_o.data == $past(dcc_tx_byte_i)) else $error("dcc insert");
  AST_OW_RATE: assert property (ow_rx_ck_o && seen |-> gap inside {9'h09B, 9'h09C}) else $error("ck rate");
  AST_OW_OCT: assert property (ow_rx_oct_o |-> ow_rx_ck_o) else $error("octet mark off tick");
  AST_OW_AIS: assert property (ow_rx_ck_o && ow_rx_ssf_o && $past(ow_rx_ssf_o, 160) |-> ow_rx_bit_o)
    else $error("orderwire ones");
  cover property (uc_tx_req_o);
  cover property (ow_rx_oct_o && !ow_rx_ssf_o);
  cover property ($rose(uc_rx_ssf_o));
endmodule // rso_adapt_asserts

bind rso_adapt rso_adapt_asserts chk_u (.mclk_i, .rst_i, .rx_tsf_i, .ow_sel_uc_i, .dcc_tx_byte_i, .uc_tx_byte_i,
  .tx_o, .uc_rx_o, .ms_ssf_o, .dcc_rx_ssf_o, .uc_rx_ssf_o, .ow_rx_ssf_o, .dcc_tx_req_o, .uc_tx_req_o,
  .ow_rx_bit_o, .ow_rx_ck_o, .ow_rx_oct_o);

// >>> bench/rso_far_model.sv
`timescale 1ns/100ps
module rso_far_model
  import rso_pkg::*;
#(
  parameter int         END_COL = 200,
  parameter logic [7:0] OW_PAT  = 8'hA5
)
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  output rso_byte_t frame_o,
  output logic      ow_bit_o,
  output logic      ow_stb_o,
  output logic      ow_oct_o
);
  logic [12:0] col;
  logic [3:0]  row;
  logic [7:0]  tick;
  logic [2:0]  bitn;
  logic        wrap;
  logic        fire;
  assign wrap = row == 4'h2 && col == 13'(END_COL);
  assign fire = tick == 8'h9B;
  initial {frame_o, ow_bit_o, ow_stb_o, ow_oct_o} = '0;
  // ----------------------------------------------------------------
  // Short frames over the overhead rows, client octets near 64 kbit/s
  // ----------------------------------------------------------------
  always @(negedge mclk_i)
  begin
    frame_o.valid <= !rst_i;
    frame_o.fs    <= !rst_i && row == 4'h0 && col == 13'h0000;
    frame_o.data  <= col[7:0];
    col  <= (rst_i || wrap || col == ROW_LEN - 13'h0001) ? 13'h0000 : col + 13'h0001;
    row  <= (rst_i || wrap) ? 4'h0 : row + 4'(col == ROW_LEN - 13'h0001);
    tick <= (rst_i || fire) ? 8'h00 : tick + 8'h01;
    bitn <= rst_i ? 3'h0 : bitn + 3'(fire);
    ow_stb_o <= !rst_i && fire;
    ow_oct_o <= !rst_i && fire && bitn == 3'h0;
    ow_bit_o <= fire ? OW_PAT[~bitn] : ~ow_bit_o;
  end
endmodule // rso_far_model

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench
  import rso_pkg::*;
;
  typedef struct packed {
    logic       tsf;
    logic       sel;
    logic       jp;
    logic       jn;
    logic [7:0] uc;
    logic [7:0] dcc;
    logic [7:0] exp_uc;
  } rso_row_t;
  localparam int       END_COL = 200;
  localparam int       EXP_MS  = 2 * (int'(ROW_LEN) - int'(SOH_COLS)) + END_COL + 1 - int'(SOH_COLS);
  localparam rso_row_t ROWS [4] = '{{4'h2, 8'h3C, 8'h81, 8'h3C}, {4'h5, 8'h3C, 8'h7E, 8'hA5},
                                    {4'h8, 8'h42, 8'h18, 8'hFF}, {4'h4, 8'h42, 8'hE7, 8'hA5}};
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  rso_byte_t  rx_i = '0;
  rso_byte_t  tx_i;
  logic       rx_tsf_i = 1'b0;
  logic       ow_sel_uc_i = 1'b0;
  logic [7:0] dcc_tx_byte_i = 8'h00;
  logic [7:0] uc_tx_byte_i = 8'h00;
  logic       ow_tx_bit_i, ow_tx_stb_i, ow_tx_oct_i;
  logic       just_pos_i = 1'b0;
  logic       just_neg_i = 1'b0;
  rso_byte_t  tx_o, ms_o, dcc_rx_o, uc_rx_o;
  logic       ms_ssf_o, dcc_rx_ssf_o, uc_rx_ssf_o, ow_rx_ssf_o, dcc_tx_req_o, uc_tx_req_o;
  logic       ow_rx_bit_o, ow_rx_ck_o, ow_rx_oct_o;
  logic [7:0] uc_got, dcc_got, ms_first, ow_sh;
  logic [3:0] ow_n;
  logic       ow_hit, ms_pend;
  int         ms_cnt, ms_last, errors, num_checks;

  rso_adapt dut_u (.*);
  rso_far_model #(.END_COL(END_COL)) far_u (.mclk_i(mclk_i), .rst_i(rst_i), .frame_o(tx_i),
    .ow_bit_o(ow_tx_bit_i), .ow_stb_o(ow_tx_stb_i), .ow_oct_o(ow_tx_oct_i));

  always #50 mclk_i = ~mclk_i;
  // ----------------------------------------------------------------
  // Loopback and capture
  // ----------------------------------------------------------------
  always @(negedge mclk_i)
  begin
    rx_i <= tx_o;
    if (uc_rx_o.valid) uc_got = uc_rx_o.data;
    if (dcc_rx_o.valid && dcc_rx_o.fs) dcc_got = dcc_rx_o.data;
    if (ms_o.valid)
    begin
      ms_cnt++;
      if (ms_pend) ms_first = ms_o.data;
      ms_pend = 1'b0;
    end
    if (rx_i.valid && rx_i.fs)
    begin
      ms_last = ms_cnt;
      ms_cnt = 0;
      ms_pend = 1'b1;
    end
    if (ow_rx_ck_o)
    begin
      ow_sh = {ow_sh[6:0], ow_rx_bit_o};
      ow_n = ow_rx_oct_o ? 4'h1 : ow_n + 4'h1;
      if (ow_n == 4'h8 && ow_sh == 8'hA5) ow_hit = 1'b1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic next_frame();
    for (int n = 0; n < 9000; n++)
    begin
      @(negedge mclk_i);
      if (tx_i.fs === 1'b1) break;
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #(100 * 90000);
    errors++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Table of channel cases, then reset
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    foreach (ROWS[i])
    begin
      {rx_tsf_i, ow_sel_uc_i, just_pos_i, just_neg_i, uc_tx_byte_i, dcc_tx_byte_i} = ROWS[i][27:8];
      next_frame();
      ow_hit = 1'b0;
      next_frame();
      repeat (4) @(negedge mclk_i);
      chk(32'(uc_got), 32'(ROWS[i].exp_uc));
      chk(32'(ow_hit), 32'(!ROWS[i].tsf));
      chk(32'({ms_ssf_o, dcc_rx_ssf_o, uc_rx_ssf_o, ow_rx_ssf_o}), 32'({4{ROWS[i].tsf}}));
      if (!ROWS[i].tsf)
      begin
        chk(32'(dcc_got), 32'(ROWS[i].dcc));
        chk(32'(ms_last), 32'(EXP_MS));
        chk(32'(ms_first), 32'(SOH_COLS[7:0]));
      end
    end
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(32'({tx_o, uc_rx_o, ms_ssf_o, ow_rx_ssf_o, ow_rx_ck_o, ow_rx_bit_o}), 32'h0000_0001);
    rst_i = 1'b0;
    next_frame();
    chk(32'({ms_ssf_o, uc_rx_ssf_o, ow_rx_ssf_o}), 32'h0000_0000);
    stop_test();
  end
endmodule // testbench
